// ===== src/icd_pkg.sv
// Shared constants and types for the IEEE-488 listener command decoder
package icd_pkg;

   // ----------------------------------------------------------------
   // Pin synchroniser layout (one bit per sampled bus line)
   // ----------------------------------------------------------------
   localparam int          ICD_SYNC_W     = 13;
   localparam int          ICD_SY_DIO_LSB = 0;
   localparam int          ICD_SY_DAV     = 8;
   localparam int          ICD_SY_ATN     = 9;
   localparam int          ICD_SY_IFC     = 10;
   localparam int          ICD_SY_REN     = 11;
   localparam int          ICD_SY_EOI     = 12;
   // Bus lines idle high (false) after reset
   localparam logic [12:0] ICD_SYNC_RST   = 13'h1FFF;

   // ----------------------------------------------------------------
   // Received word: data byte plus end flag
   // ----------------------------------------------------------------
   localparam int          ICD_WORD_W     = 9;
   localparam int          ICD_WORD_EOI   = 8;
   localparam logic [8:0]  ICD_WORD_RST   = 9'h000;

   // ----------------------------------------------------------------
   // Multiline command codes, seven bits
   // ----------------------------------------------------------------
   localparam logic [6:0]  ICD_GTL        = 7'h01;
   localparam logic [6:0]  ICD_SDC        = 7'h04;
   localparam logic [6:0]  ICD_PPC        = 7'h05;
   localparam logic [6:0]  ICD_GET        = 7'h08;
   localparam logic [6:0]  ICD_TCT        = 7'h09;
   localparam logic [6:0]  ICD_LLO        = 7'h11;
   localparam logic [6:0]  ICD_DCL        = 7'h14;
   localparam logic [6:0]  ICD_PPU        = 7'h15;
   localparam logic [6:0]  ICD_SPE        = 7'h18;
   localparam logic [6:0]  ICD_SPD        = 7'h19;
   localparam logic [6:0]  ICD_UNL        = 7'h3F;
   localparam logic [6:0]  ICD_UNT        = 7'h5F;
   // Group selector in bits 6:5
   localparam logic [1:0]  ICD_GRP_LAG    = 2'h1;
   localparam logic [1:0]  ICD_GRP_TAG    = 2'h2;
   localparam logic [1:0]  ICD_GRP_SCG    = 2'h3;

   // ----------------------------------------------------------------
   // Acceptor handshake states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ICD_AH_OFF  = 3'h0,
      ICD_AH_IDLE = 3'h1,
      ICD_AH_RDY  = 3'h2,
      ICD_AH_ACC  = 3'h3,
      ICD_AH_DONE = 3'h4
   } icd_ah_t;

endpackage

// ===== src/icd_buf2.sv
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module icd_buf2
   import icd_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  in_valid,
   input  wire logic [ICD_WORD_W-1:0] in_data,
   output logic                       in_ready,
   output logic                       out_valid,
   output logic [ICD_WORD_W-1:0]      out_data,
   input  wire logic                  out_ready
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                  head_v;
      logic [ICD_WORD_W-1:0] head;
      logic                  tail_v;
      logic [ICD_WORD_W-1:0] tail;
      logic                  rdy;
   } icd_buf_t;

   icd_buf_t st_reg;
   icd_buf_t st_next;
   logic     pop;
   logic     push;

   assign pop  = st_reg.head_v & out_ready;
   assign push = in_valid & st_reg.rdy;

   // Head is the output word, tail holds a word stalled behind it
   always_comb begin
      st_next = st_reg;
      if (pop) begin
         if (st_reg.tail_v) begin
            st_next.head   = st_reg.tail;
            st_next.tail_v = push;
            st_next.tail   = in_data;
         end else begin
            st_next.head_v = push;
            st_next.head   = in_data;
         end
      end else if (push) begin
         if (!st_reg.head_v) begin
            st_next.head_v = 1'b1;
            st_next.head   = in_data;
         end else begin
            st_next.tail_v = 1'b1;
            st_next.tail   = in_data;
         end
      end
      // Ready registered so it never depends on out_ready combinationally
      st_next.rdy = !st_next.tail_v;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '{head_v: 1'b0, head: ICD_WORD_RST, tail_v: 1'b0, tail: ICD_WORD_RST, rdy: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign in_ready  = st_reg.rdy;
   assign out_valid = st_reg.head_v;
   assign out_data  = st_reg.head;

   // Nothing is dropped when full
   buf_full_a: assert property (@(posedge clk) disable iff (rst)
      (!st_reg.rdy && !out_ready) |=> (st_reg.head_v && st_reg.tail_v))
      else $error("buffer lost a word while stalled");

endmodule

// ===== src/icd_decoder.sv
// IEEE-488 listener-side multiline command decoder with acceptor handshake
// How it works
// RQ1 - Addressed commands act only after own listen address in this attention sequence.
// RQ2 - Controller keeps ATN true over listen address and following addressed command.
// RQ3 - Selective Device Clear while addressed pulses the device clear output.
// RQ4 - Go To Local while addressed leaves remote mode.
// RQ5 - Group Execute Trigger pulses the trigger output.
// RQ6 - Primary address with bit 5 set makes the device listener addressed.
// RQ7 - Primary address with bit 6 set makes the device talker addressed.
// RQ8 - Secondary command group bytes have no addressing effect.
// RQ9 - Unlisten with ATN true drops listener addressing.
// RQ10 - Untalk with ATN true drops talker addressing.
// RQ11 - Local Lockout, Device Clear, Serial Poll Enable and Disable need no addressing.
// RQ12 - Bytes taken with ATN false go out as plain data.
// RQ13 - Controller sends Unlisten, listen address, command, all with ATN true.
// RQ14 - Controller raises ATN before sending a data string.
// RQ15 - Parallel poll configure, unconfigure and take control are ignored.
// RQ16 - NRFD held until ready; NDAC released only once the byte is taken.
// RQ17 - Interface clear drops both talker and listener addressing.
// RQ18 - Device Clear resets the device without addressing.
// RQ19 - Commands decode from the low seven data lines only.
`timescale 1ns/100ps
module icd_decoder
   import icd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [4:0] my_addr,
   input  wire logic [7:0] dio_n_in,
   input  wire logic       dav_n_in,
   input  wire logic       atn_n_in,
   input  wire logic       ifc_n_in,
   input  wire logic       ren_n_in,
   input  wire logic       eoi_n_in,
   output logic            nrfd_n_out,
   output logic            nrfd_n_oe,
   output logic            ndac_n_out,
   output logic            ndac_n_oe,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_end,
   input  wire logic       rx_ready,
   output logic            listen_active,
   output logic            talk_active,
   output logic            remote_mode,
   output logic            local_lockout,
   output logic            serial_poll,
   output logic            device_clear,
   output logic            trigger
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ICD_SYNC_W-1:0] s1;
      logic [ICD_SYNC_W-1:0] s2;
      icd_ah_t               ah;
      logic                  listen;
      logic                  talk;
      logic                  mla_seen;
      logic                  remote;
      logic                  lockout;
      logic                  spoll;
      logic                  clear;
      logic                  trig;
      logic                  nrfd_oe;
      logic                  ndac_oe;
      logic                  push;
      logic [ICD_WORD_W-1:0] pdata;
   } icd_state_t;

   icd_state_t            st_reg;
   icd_state_t            st_next;
   logic                  buf_ready;
   logic [ICD_WORD_W-1:0] buf_data;
   logic                  dav_t;
   logic                  atn_t;
   logic                  ifc_t;
   logic                  ren_t;
   logic                  eoi_t;
   logic [7:0]            bus_byte;
   logic [6:0]            cmd;
   logic                  cap;
   logic                  cmd_cap;
   logic                  is_mla;
   logic                  is_mta;

   // ----------------------------------------------------------------
   // Decoded views of the second synchroniser stage (bus is low-true)
   // ----------------------------------------------------------------
   assign dav_t    = !st_reg.s2[ICD_SY_DAV];
   assign atn_t    = !st_reg.s2[ICD_SY_ATN];
   assign ifc_t    = !st_reg.s2[ICD_SY_IFC];
   assign ren_t    = !st_reg.s2[ICD_SY_REN];
   assign eoi_t    = !st_reg.s2[ICD_SY_EOI];
   assign bus_byte = ~st_reg.s2[ICD_SY_DIO_LSB +: 8];
   assign cmd      = bus_byte[6:0];                           // [RQ19]
   // Byte is taken in RDY once DAV is seen and there is somewhere to put it
   assign cap      = (st_reg.ah == ICD_AH_RDY) && dav_t && (atn_t || buf_ready); // [RQ16]
   assign cmd_cap  = cap && atn_t;
   // Unlisten and untalk share the group codes, so exclude them here
   assign is_mla   = (cmd[6:5] == ICD_GRP_LAG) && (cmd != ICD_UNL) && (cmd[4:0] == my_addr); // [RQ6]
   assign is_mta   = (cmd[6:5] == ICD_GRP_TAG) && (cmd != ICD_UNT) && (cmd[4:0] == my_addr); // [RQ7]

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_next       = st_reg;
      st_next.s1    = {eoi_n_in, ren_n_in, ifc_n_in, atn_n_in, dav_n_in, dio_n_in};
      st_next.s2    = st_reg.s1;
      st_next.clear = 1'b0;
      st_next.trig  = 1'b0;
      st_next.push  = 1'b0;

      // Acceptor handshake; takes no part unless commanded or listening
      case (st_reg.ah)
         ICD_AH_OFF: begin
            if (atn_t || st_reg.listen) begin
               st_next.ah = ICD_AH_IDLE;
            end
         end
         ICD_AH_IDLE: begin
            // Hold off until the previous DAV is gone and a data byte has room
            if (!dav_t && (atn_t || buf_ready)) begin
               st_next.ah = ICD_AH_RDY;                        // [RQ16]
            end
         end
         ICD_AH_RDY: begin
            if (cap) begin
               st_next.ah = ICD_AH_ACC;
            end else if (!dav_t && !atn_t && !buf_ready) begin
               st_next.ah = ICD_AH_IDLE;
            end
         end
         ICD_AH_ACC: begin
            st_next.ah = ICD_AH_DONE;
         end
         ICD_AH_DONE: begin
            if (!dav_t) begin
               st_next.ah = ICD_AH_IDLE;
            end
         end
         default: begin
            st_next.ah = ICD_AH_OFF;
         end
      endcase
      if (!atn_t && !st_reg.listen) begin
         st_next.ah = ICD_AH_OFF;
      end

      // Command decode while ATN is true
      if (cmd_cap) begin
         if (cmd == ICD_UNL) begin
            st_next.listen   = 1'b0;                           // [RQ9]
            st_next.mla_seen = 1'b0;
         end else if (cmd == ICD_UNT) begin
            st_next.talk     = 1'b0;                           // [RQ10]
         end else if (is_mla) begin
            st_next.listen   = 1'b1;                           // [RQ6]
            st_next.mla_seen = 1'b1;
            st_next.talk     = 1'b0;
            st_next.remote   = st_reg.remote | ren_t;
         end else if (is_mta) begin
            st_next.talk     = 1'b1;                           // [RQ7]
            st_next.listen   = 1'b0;
            st_next.mla_seen = 1'b0;
         end else if (cmd[6:5] == ICD_GRP_TAG) begin
            // Another device's talk address unaddresses us as talker
            st_next.talk     = 1'b0;
         end
         // Secondary group and unlisted codes fall through untouched [RQ8] [RQ15]
         case (cmd)
            ICD_GTL: if (st_reg.mla_seen) st_next.remote = 1'b0;     // [RQ4] [RQ1]
            ICD_SDC: if (st_reg.mla_seen) st_next.clear = 1'b1;      // [RQ3] [RQ1]
            ICD_GET: st_next.trig    = 1'b1;                         // [RQ5]
            ICD_LLO: st_next.lockout = 1'b1;                         // [RQ11]
            ICD_DCL: st_next.clear   = 1'b1;                         // [RQ18] [RQ11]
            ICD_SPE: st_next.spoll   = 1'b1;                         // [RQ11]
            ICD_SPD: st_next.spoll   = 1'b0;                         // [RQ11]
            default: st_next.spoll   = st_next.spoll;
         endcase
      end

      // Data bytes with ATN false go to the buffer with their end flag
      if (cap && !atn_t && st_reg.listen) begin
         st_next.push  = 1'b1;                                 // [RQ12]
         st_next.pdata = {eoi_t, bus_byte};
      end

      // Addressed commands only count within one attention sequence
      if (!atn_t) begin
         st_next.mla_seen = 1'b0;                              // [RQ1]
      end
      // Remote enable false drops remote and lockout
      if (!ren_t) begin
         st_next.remote  = 1'b0;
         st_next.lockout = 1'b0;
      end
      // Interface clear wins over addressing and serial poll changes from a command taken in the same cycle
      if (ifc_t) begin
         st_next.listen   = 1'b0;                              // [RQ17]
         st_next.talk     = 1'b0;
         st_next.mla_seen = 1'b0;
         st_next.spoll    = 1'b0;
      end

      // Line drives follow the next handshake state so they are registered
      st_next.nrfd_oe = (st_next.ah == ICD_AH_IDLE) || (st_next.ah == ICD_AH_ACC) ||
                        (st_next.ah == ICD_AH_DONE);          // [RQ16]
      st_next.ndac_oe = (st_next.ah == ICD_AH_IDLE) || (st_next.ah == ICD_AH_RDY) ||
                        (st_next.ah == ICD_AH_ACC);           // [RQ16]
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '{s1: ICD_SYNC_RST, s2: ICD_SYNC_RST, ah: ICD_AH_OFF, pdata: ICD_WORD_RST, default: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Data buffer: a stalled reader holds NRFD low, never drops a byte
   // ----------------------------------------------------------------
   icd_buf2 u_buf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (st_reg.push),
      .in_data   (st_reg.pdata),
      .in_ready  (buf_ready),
      .out_valid (rx_valid),
      .out_data  (buf_data),
      .out_ready (rx_ready)
   );

   // Open-drain lines only ever pull low
   assign nrfd_n_out    = 1'b0;
   assign ndac_n_out    = 1'b0;
   assign nrfd_n_oe     = st_reg.nrfd_oe;
   assign ndac_n_oe     = st_reg.ndac_oe;
   assign rx_data       = buf_data[7:0];
   assign rx_end        = buf_data[ICD_WORD_EOI];
   assign listen_active = st_reg.listen;
   assign talk_active   = st_reg.talk;
   assign remote_mode   = st_reg.remote;
   assign local_lockout = st_reg.lockout;
   assign serial_poll   = st_reg.spoll;
   assign device_clear  = st_reg.clear;
   assign trigger       = st_reg.trig;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence take_cmd_s(logic [6:0] c);
      cmd_cap && !ifc_t && (cmd == c);
   endsequence
   sequence hs_end_s;
      nrfd_n_oe && ndac_n_oe ##1 nrfd_n_oe && !ndac_n_oe;
   endsequence

   sdc_addr_a:  assert property (take_cmd_s(ICD_SDC) |=> (device_clear == $past(st_reg.mla_seen))) // [RQ3]
      else $error("selective clear did not follow addressing");
   sdc_unad_a:  assert property (take_cmd_s(ICD_SDC) ##0 !st_reg.mla_seen |=> !device_clear) // [RQ1]
      else $error("unaddressed selective clear acted");
   gtl_local_a: assert property (take_cmd_s(ICD_GTL) ##0 st_reg.mla_seen |=> !remote_mode) // [RQ4]
      else $error("go to local left remote set");
   get_trig_a:  assert property (take_cmd_s(ICD_GET) |=> trigger ##1 !trigger) // [RQ5]
      else $error("trigger not a single pulse");
   mla_set_a:   assert property (cmd_cap && !ifc_t && is_mla |=> listen_active && !talk_active) // [RQ6]
      else $error("own listen address not taken");
   mta_set_a:   assert property (cmd_cap && !ifc_t && is_mta |=> talk_active && !listen_active) // [RQ7]
      else $error("own talk address not taken");
   scg_keep_a:  assert property (cmd_cap && !ifc_t && cmd[6:5] == ICD_GRP_SCG // [RQ8]
                                 |=> $stable(listen_active) && $stable(talk_active))
      else $error("secondary byte changed addressing");
   unl_drop_a:  assert property (take_cmd_s(ICD_UNL) |=> !listen_active) // [RQ9]
      else $error("unlisten ignored");
   unt_drop_a:  assert property (take_cmd_s(ICD_UNT) |=> !talk_active) // [RQ10]
      else $error("untalk ignored");
   dcl_clear_a: assert property (take_cmd_s(ICD_DCL) |=> device_clear) // [RQ18]
      else $error("device clear ignored");
   data_push_a: assert property (cap && !atn_t && listen_active // [RQ12]
                                 |=> st_reg.push && st_reg.pdata[7:0] == $past(bus_byte))
      else $error("data byte not passed on");
   pp_ignore_a: assert property (cmd_cap && !ifc_t && (cmd == ICD_PPC || cmd == ICD_PPU || cmd == ICD_TCT) // [RQ15]
                                 |=> !device_clear && !trigger && $stable(serial_poll))
      else $error("unsupported command had an effect");
   hs_accept_a: assert property (cap |=> hs_end_s) // [RQ16]
      else $error("NDAC released before byte taken");
   ifc_idle_a:  assert property (ifc_t |=> !listen_active && !talk_active) // [RQ17]
      else $error("interface clear left device addressed");

endmodule

// ===== sim/icd_ctrl_model.sv
// Bus controller model: source handshake plus ATN, IFC and REN lines
`timescale 1ns/100ps
module icd_ctrl_model (
   input  wire logic clk,
   input  wire logic nrfd_n,
   input  wire logic ndac_n,
   output logic [7:0] dio_n,
   output logic       dav_n,
   output logic       atn_n,
   output logic       ifc_n,
   output logic       ren_n,
   output logic       eoi_n
);
   localparam int LIM = 2000;
   int   lat = 0;
   int   hs_err = 0;
   logic busy = 1'b0;

   // Lines start false; released lines float to the pull-up level
   initial begin
      dio_n = 8'hFF;
      dav_n = 1'b1;
      atn_n = 1'b1;
      ifc_n = 1'b1;
      ren_n = 1'b1;
      eoi_n = 1'b1;
   end

   // One byte through the interlocked handshake; tk stays low when nobody accepts
   task automatic send(input logic atn, input logic [7:0] b, input logic eoi, input int gap, output logic tk);
      int n;
      tk = 1'b0;
      busy = 1'b1;
      @(posedge clk);
      #1;
      if (atn_n !== ~atn) begin
         atn_n = ~atn;
         repeat (25) @(posedge clk);              // Acceptors get 100 ns to settle
         #1;
      end
      n = 0;
      while (nrfd_n !== 1'b1 && n < LIM) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == LIM) begin
         hs_err++;
      end else if (ndac_n === 1'b0) begin
         dio_n = ~b;
         eoi_n = ~eoi;
         repeat (gap) @(posedge clk);
         #1;
         dav_n = 1'b0;
         n = 0;
         while (ndac_n !== 1'b1 && n < LIM) begin
            @(posedge clk);
            #1;
            n++;
         end
         lat = n;
         if (n == LIM || nrfd_n !== 1'b0) hs_err++;
         dav_n = 1'b1;
         dio_n = 8'hFF;
         eoi_n = 1'b1;
         tk = 1'b1;
      end
      busy = 1'b0;
   endtask

   // Remote enable level, held long enough to pass the synchroniser
   task automatic set_ren(input logic on);
      @(posedge clk);
      #1;
      ren_n = ~on;
      repeat (6) @(posedge clk);
   endtask

   // Interface clear pulse
   task automatic ifc_pulse();
      @(posedge clk);
      #1;
      ifc_n = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      ifc_n = 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ===== sim/icd_decoder_tb_top.sv
// Self-checking bench for the listener command decoder
`timescale 1ns/100ps
module icd_decoder_tb_top
   import icd_pkg::*;
;
   logic       clk;
   logic       rst;
   logic       stall;
   logic       rx_ready;
   logic [4:0] my_addr;
   logic [7:0] dio_n;
   logic [7:0] rx_data;
   logic       dav_n, atn_n, ifc_n, ren_n, eoi_n, nrfd_n, ndac_n;
   logic       nrfd_out, nrfd_oe, ndac_out, ndac_oe, rx_valid, rx_end;
   logic       listen_active, talk_active, remote_mode, local_lockout, serial_poll, device_clear, trigger;
   int         seed = 32'h7A81;
   int         n_fail = 0, compares = 0, dc_exp = 0, dc_seen = 0, tg_exp = 0, tg_seen = 0;
   int         ls = 0, tk_m = 0, rm = 0, ll = 0, sp = 0, mla = 0, ren = 0;
   logic [8:0] exp_q[$];
   logic [4:0] addr_tab [3] = '{5'h10, 5'h00, 5'h1E};
   logic [6:0] uni_tab [9] = '{ICD_LLO, ICD_DCL, ICD_SPE, ICD_SPD, ICD_GET, ICD_PPC, ICD_PPU, ICD_TCT, ICD_SPE};

   // Clock and open-drain wires (pull-up unless our acceptor pulls)
   initial clk = 1'b0;
   always #2 clk = ~clk;
   assign nrfd_n = nrfd_oe ? nrfd_out : 1'b1;
   assign ndac_n = ndac_oe ? ndac_out : 1'b1;

   icd_decoder icd_decoder_inst (.clk(clk), .rst(rst), .my_addr(my_addr), .dio_n_in(dio_n), .dav_n_in(dav_n),
      .atn_n_in(atn_n), .ifc_n_in(ifc_n), .ren_n_in(ren_n), .eoi_n_in(eoi_n), .nrfd_n_out(nrfd_out),
      .nrfd_n_oe(nrfd_oe), .ndac_n_out(ndac_out), .ndac_n_oe(ndac_oe), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_end(rx_end), .rx_ready(rx_ready), .listen_active(listen_active), .talk_active(talk_active),
      .remote_mode(remote_mode), .local_lockout(local_lockout), .serial_poll(serial_poll),
      .device_clear(device_clear), .trigger(trigger));
   icd_ctrl_model icd_ctrl_model_inst (.clk(clk), .nrfd_n(nrfd_n), .ndac_n(ndac_n), .dio_n(dio_n), .dav_n(dav_n),
      .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n), .eoi_n(eoi_n));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Consumer stalls at random; a stall phase holds it off completely
   always @(posedge clk) begin
      #1;
      rx_ready = !stall && ($random(seed) % 4 != 0);
   end

   // Pulses are counted per cycle, so a long pulse shows up as extra counts
   always @(negedge clk) begin
      if (rst === 1'b0) begin
         if (device_clear === 1'b1) dc_seen++;
         if (trigger === 1'b1) tg_seen++;
         if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            chk(32'(exp_q.size() != 0), 32'h1);
            if (exp_q.size() != 0) chk(32'({rx_end, rx_data}), 32'(exp_q.pop_front()));
         end
      end
   end

   // Reference model of addressing and command effects
   task automatic apply(input logic [6:0] c);
      if (c == ICD_UNL) begin
         ls = 0;
         mla = 0;
      end else if (c == ICD_UNT) begin
         tk_m = 0;
      end else if (c[6:5] == ICD_GRP_LAG) begin
         if (c[4:0] == my_addr) begin
            ls = 1;
            mla = 1;
            tk_m = 0;
            rm = rm | ren;
         end
      end else if (c[6:5] == ICD_GRP_TAG) begin
         tk_m = int'(c[4:0] == my_addr);
         if (tk_m == 1) begin
            ls = 0;
            mla = 0;
         end
      end else if (c[6:5] == 2'h0) begin
         case (c)
            ICD_GTL: if (mla == 1) rm = 0;
            ICD_SDC: dc_exp += mla;
            ICD_GET: tg_exp++;
            ICD_LLO: ll = 1;
            ICD_DCL: dc_exp++;
            ICD_SPE: sp = 1;
            ICD_SPD: sp = 0;
            default: ;
         endcase
      end
   endtask

   task automatic check_state();
      chk(32'(listen_active), ls);
      chk(32'(talk_active), tk_m);
      chk(32'(remote_mode), rm);
      chk(32'(local_lockout), ll);
      chk(32'(serial_poll), sp);
      chk(dc_seen, dc_exp);
      chk(tg_seen, tg_exp);
      chk(icd_ctrl_model_inst.hs_err, 0);
      if (icd_ctrl_model_inst.hs_err != 0) finish_test();
   endtask

   // Command byte with ATN true; the top data line carries noise
   task automatic cmd(input logic [6:0] c);
      logic tk;
      logic b7;
      b7 = 1'($random(seed));
      icd_ctrl_model_inst.send(1'b1, {b7, c}, 1'b0, $random(seed) & 3, tk);
      apply(c);
      repeat (2) @(posedge clk);
      chk(32'(tk), 1);
      chk(32'(icd_ctrl_model_inst.lat >= 4), 1);
      check_state();
   endtask

   // Data byte with ATN false; ends the attention period
   task automatic dat(input logic [7:0] b, input logic e);
      logic tk;
      mla = 0;
      if (ls == 1) exp_q.push_back({e, b});
      icd_ctrl_model_inst.send(1'b0, b, e, $random(seed) & 3, tk);
      chk(32'(tk), ls);
      check_state();
   endtask

   initial begin
      rst = 1'b1;
      stall = 1'b0;
      rx_ready = 1'b0;
      my_addr = 5'h10;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      foreach (addr_tab[k]) begin
         my_addr = addr_tab[k];
         icd_ctrl_model_inst.set_ren(1'b1);
         ren = 1;
         cmd(ICD_UNL);
         cmd({ICD_GRP_LAG, my_addr});
         cmd(ICD_SDC);
         cmd(ICD_GTL);
         cmd({ICD_GRP_LAG, my_addr});
         dat(8'h2A, 1'b0);
         dat(8'($random(seed)), 1'b1);
         cmd(ICD_GTL);
         cmd(ICD_SDC);
         cmd({ICD_GRP_LAG, my_addr ^ 5'h04});
         cmd({ICD_GRP_SCG, my_addr});
         cmd({ICD_GRP_TAG, my_addr});
         cmd({ICD_GRP_TAG, my_addr ^ 5'h04});
         cmd({ICD_GRP_TAG, my_addr});
         cmd(ICD_UNT);
         cmd(ICD_UNL);
         dat(8'h52, 1'b0);
         foreach (uni_tab[j]) cmd(uni_tab[j]);
         cmd({ICD_GRP_LAG, my_addr});
         icd_ctrl_model_inst.ifc_pulse();
         ls = 0;
         tk_m = 0;
         sp = 0;
         mla = 0;
         check_state();
         icd_ctrl_model_inst.set_ren(1'b0);
         ren = 0;
         rm = 0;
         ll = 0;
         check_state();
         $display("Done: addressing at address %0d", my_addr);
      end
      // Random mix of commands and data with remote enabled
      icd_ctrl_model_inst.set_ren(1'b1);
      ren = 1;
      repeat (60) begin
         if ($random(seed) % 4 == 0) dat(8'($random(seed)), 1'($random(seed)));
         else cmd(7'($random(seed)));
      end
      $display("Done: random mix");
      // Stalled consumer: the buffer fills and NRFD holds the source off
      cmd(ICD_UNL);
      cmd({ICD_GRP_LAG, my_addr});
      stall = 1'b1;
      fork
         for (int i = 0; i < 6; i++) dat(8'(8'h41 + i), 1'(i == 5));
         begin
            repeat (400) @(posedge clk);
            chk(32'(icd_ctrl_model_inst.busy), 1);
            chk(32'(nrfd_n), 0);
            stall = 1'b0;
         end
      join
      for (int n = 0; n < 2000 && exp_q.size() != 0; n++) @(posedge clk);
      chk(32'(exp_q.size()), 0);
      $display("Done: stalled consumer");
      finish_test();
   end
endmodule
